// >>> ccz_can_ctl0.v
// CAN controller control register zero with its handshakes, timer and AXI4-Lite slave.
// Assumes the protocol engine runs on aclk and drives its status inputs on that clock;
// only the CAN receive pin is asynchronous.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "ccz_defines.vh"
module ccz_can_ctl0 (
  input  wire                   aclk,
  input  wire                   aresetn,
  input  wire [`CCZ_ADDR_W-1:0] s_axi_awaddr,
  input  wire                   s_axi_awvalid,
  output wire                   s_axi_awready,
  input  wire [31:0]            s_axi_wdata,
  input  wire [3:0]             s_axi_wstrb,
  input  wire                   s_axi_wvalid,
  output wire                   s_axi_wready,
  output wire [1:0]             s_axi_bresp,
  output wire                   s_axi_bvalid,
  input  wire                   s_axi_bready,
  input  wire [`CCZ_ADDR_W-1:0] s_axi_araddr,
  input  wire                   s_axi_arvalid,
  output wire                   s_axi_arready,
  output wire [31:0]            s_axi_rdata,
  output wire [1:0]             s_axi_rresp,
  output wire                   s_axi_rvalid,
  input  wire                   s_axi_rready,
  input  wire                   rx_pin,
  input  wire                   tx_bit_in,
  input  wire                   rx_frame_valid,
  input  wire                   rx_active_in,
  input  wire                   bus_synced_in,
  input  wire                   tx_buffers_empty,
  input  wire                   bit_clk_tick,
  input  wire                   msg_acked,
  input  wire                   cpu_wait_mode,
  output wire                   transmit_pin,
  output wire                   engine_init,
  output wire                   engine_sleep,
  output wire                   bus_if_clk_stop,
  output wire                   stamp_we,
  output wire [15:0]            stamp_value,
  output wire                   irq
);

  localparam [7:0]      CTL0_RST = `CCZ_CTL0_RESET;
  reg                   awready_r;
  reg                   wready_r;
  reg                   bvalid_r;
  reg  [1:0]            bresp_r;
  reg                   arready_r;
  reg                   rvalid_r;
  reg  [1:0]            rresp_r;
  reg  [31:0]           rdata_r;
  reg                   aw_held_r;
  reg                   w_held_r;
  reg  [`CCZ_ADDR_W-1:0] aw_addr_r;
  reg  [7:0]            w_data_r;
  reg                   w_lane0_r;

  reg                   received_frame_flag_r;
  reg                   stop_in_wait_r;
  reg                   timen_r;
  reg                   wakeup_enable_r;
  reg                   sleep_request_r;
  reg                   init_request_r;
  reg                   init_ack_r;
  reg                   sleep_ack_r;
  reg                   wakeup_enable_sleep_r;
  reg                   rx_prev_r;
  reg  [15:0]           timer_r;
  reg  [`CCZ_IRQ_W-1:0] irq_stat_r;
  reg  [`CCZ_IRQ_W-1:0] irq_mask_r;
  reg                   irq_r;
  reg                   tx_pin_r;
  reg                   clk_stop_r;
  reg                   stamp_we_r;
  reg  [15:0]           stamp_r;

  wire                  rx_sync;
  wire                  aw_take  = s_axi_awvalid & awready_r;
  wire                  w_take   = s_axi_wvalid & wready_r;
  wire                  ar_take  = s_axi_arvalid & arready_r;
  wire                  do_wr    = aw_held_r & w_held_r & ~bvalid_r;
  wire                  aw_held_nxt = do_wr ? 1'b0 : (aw_held_r | aw_take);
  wire                  w_held_nxt  = do_wr ? 1'b0 : (w_held_r | w_take);
  wire                  bvalid_nxt  = do_wr | (bvalid_r & ~s_axi_bready);
  wire                  rvalid_nxt  = ar_take | (rvalid_r & ~s_axi_rready);

  wire                  init_mode = init_request_r & init_ack_r;
  // Outside init excludes the entry and exit transitions as well as the settled mode
  wire                  wr_ok     = ~init_request_r & ~init_ack_r;
  wire                  wr_ctl0   = do_wr & w_lane0_r & (aw_addr_r == `CCZ_OFF_CTL0);
  wire                  wr_mask   = do_wr & w_lane0_r & (aw_addr_r == `CCZ_OFF_IRQ_MASK);
  wire                  bus_idle  = ~rx_active_in & tx_buffers_empty;
  wire                  sleeping  = sleep_request_r & sleep_ack_r;
  // A dominant edge on the bus counts as traffic
  wire                  wake_evt  = sleeping & wakeup_enable_sleep_r & rx_prev_r & ~rx_sync;
  wire                  rd_stat   = ar_take & (s_axi_araddr == `CCZ_OFF_IRQ_STAT);
  wire                  wait_stop = cpu_wait_mode & stop_in_wait_r;

  reg  [`CCZ_IRQ_W-1:0] irq_stat_nxt;
  reg                   received_frame_flag_nxt;
  reg                   sleep_request_nxt;
  reg                   init_request_nxt;
  reg  [7:0]            ctl0_rd;
  reg  [31:0]           rd_mux;
  reg                   rd_hit;

  ccz_sync #(
    .W(1)
  ) u_rx_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .async_in  (rx_pin),
    .reset_val (1'b1),
    .sync_out  (rx_sync)
  );

  always @* begin
    // Hardware set beats a write-one clear in the same cycle
    received_frame_flag_nxt = rx_frame_valid | (received_frame_flag_r & ~(wr_ctl0 & wr_ok & w_data_r[`CCZ_BIT_RECEIVED_FRAME_FLAG]));
    if (init_mode) begin
      received_frame_flag_nxt = 1'b0;
    end
    init_request_nxt = init_request_r;
    if (wr_ctl0) begin
      // Clearing is refused until the acknowledge has come
      if (w_data_r[`CCZ_BIT_INIT_REQUEST] | ~init_request_r | init_ack_r) begin
        init_request_nxt = w_data_r[`CCZ_BIT_INIT_REQUEST];
      end
    end
    sleep_request_nxt = sleep_request_r;
    if (wr_ctl0 & wr_ok) begin
      if (w_data_r[`CCZ_BIT_SLEEP_REQUEST] | ~sleep_request_r | sleep_ack_r) begin
        sleep_request_nxt = w_data_r[`CCZ_BIT_SLEEP_REQUEST];
      end
    end
    if (wake_evt) begin
      sleep_request_nxt = 1'b0;
    end
    irq_stat_nxt = rd_stat ? {`CCZ_IRQ_W{1'b0}} : irq_stat_r;
    irq_stat_nxt[`CCZ_IRQ_RECEIVED_FRAME_FLAG] = irq_stat_nxt[`CCZ_IRQ_RECEIVED_FRAME_FLAG] | (rx_frame_valid & ~init_mode);
    irq_stat_nxt[`CCZ_IRQ_WAKE]  = irq_stat_nxt[`CCZ_IRQ_WAKE] | wake_evt;
  end

  always @* begin
    // Live status reads as reset while init mode holds the register
    ctl0_rd = 8'h00;
    ctl0_rd[`CCZ_BIT_RECEIVED_FRAME_FLAG]  = received_frame_flag_r;
    // No loopback path exists here, so both receive flags always carry meaning
    ctl0_rd[`CCZ_BIT_RECEIVER_ACTIVE]  = rx_active_in & ~init_mode;
    ctl0_rd[`CCZ_BIT_STOP_IN_WAIT]  = stop_in_wait_r;
    ctl0_rd[`CCZ_BIT_BUS_SYNCHRONIZED]  = bus_synced_in & ~init_request_r;
    ctl0_rd[`CCZ_BIT_TIMEN]  = timen_r;
    ctl0_rd[`CCZ_BIT_WAKEUP_ENABLE]   = wakeup_enable_r;
    ctl0_rd[`CCZ_BIT_SLEEP_REQUEST]  = sleep_request_r;
    ctl0_rd[`CCZ_BIT_INIT_REQUEST] = init_request_r;
    rd_hit = 1'b1;
    rd_mux = 32'h00000000;
    case (s_axi_araddr)
      `CCZ_OFF_CTL0: begin
        rd_mux[7:0] = ctl0_rd;
      end
      `CCZ_OFF_CTL1: begin
        rd_mux[`CCZ_BIT_INIT_ACKNOWLEDGE] = init_ack_r;
        rd_mux[`CCZ_BIT_SLEEP_ACKNOWLEDGE]  = sleep_ack_r;
      end
      `CCZ_OFF_TIMER: begin
        rd_mux[15:0] = timer_r;
      end
      `CCZ_OFF_IRQ_STAT: begin
        rd_mux[`CCZ_IRQ_W-1:0] = irq_stat_r;
      end
      `CCZ_OFF_IRQ_MASK: begin
        rd_mux[`CCZ_IRQ_W-1:0] = irq_mask_r;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `CCZ_RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rresp_r   <= `CCZ_RESP_OKAY;
      rdata_r   <= 32'h00000000;
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= {`CCZ_ADDR_W{1'b0}};
      w_data_r  <= 8'h00;
      w_lane0_r <= 1'b0;
    end else begin
      awready_r <= ~aw_held_nxt & ~bvalid_nxt;
      wready_r  <= ~w_held_nxt & ~bvalid_nxt;
      arready_r <= ~rvalid_nxt;
      aw_held_r <= aw_held_nxt;
      w_held_r  <= w_held_nxt;
      bvalid_r  <= bvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      if (aw_take) begin
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_r  <= s_axi_wdata[7:0];
        w_lane0_r <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        bresp_r <= (aw_addr_r == `CCZ_OFF_CTL0 || aw_addr_r == `CCZ_OFF_CTL1 ||
                    aw_addr_r == `CCZ_OFF_TIMER || aw_addr_r == `CCZ_OFF_IRQ_STAT ||
                    aw_addr_r == `CCZ_OFF_IRQ_MASK) ? `CCZ_RESP_OKAY : `CCZ_RESP_SLVERR;
      end
      if (ar_take) begin
        rdata_r <= rd_mux;
        rresp_r <= rd_hit ? `CCZ_RESP_OKAY : `CCZ_RESP_SLVERR;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      received_frame_flag_r      <= CTL0_RST[`CCZ_BIT_RECEIVED_FRAME_FLAG];
      stop_in_wait_r      <= CTL0_RST[`CCZ_BIT_STOP_IN_WAIT];
      timen_r      <= CTL0_RST[`CCZ_BIT_TIMEN];
      wakeup_enable_r       <= CTL0_RST[`CCZ_BIT_WAKEUP_ENABLE];
      sleep_request_r      <= CTL0_RST[`CCZ_BIT_SLEEP_REQUEST];
      init_request_r     <= CTL0_RST[`CCZ_BIT_INIT_REQUEST];
      init_ack_r   <= 1'b0;
      sleep_ack_r  <= 1'b0;
      wakeup_enable_sleep_r <= 1'b0;
      rx_prev_r    <= 1'b1;
      irq_stat_r   <= {`CCZ_IRQ_W{1'b0}};
      irq_mask_r   <= `CCZ_MASK_RESET;
      irq_r        <= 1'b0;
    end else begin
      received_frame_flag_r    <= received_frame_flag_nxt;
      init_request_r   <= init_request_nxt;
      sleep_request_r    <= sleep_request_nxt;
      rx_prev_r  <= rx_sync;
      irq_stat_r <= irq_stat_nxt;
      irq_r      <= |(irq_stat_nxt & irq_mask_r);
      if (wr_mask) begin
        irq_mask_r <= w_data_r[`CCZ_IRQ_W-1:0];
      end
      // The engine aborts and drops sync on the request; acknowledge follows a cycle later
      init_ack_r <= init_request_r;
      if (init_mode) begin
        stop_in_wait_r <= 1'b0;
        timen_r <= 1'b0;
      end else if (wr_ctl0 & wr_ok) begin
        stop_in_wait_r <= w_data_r[`CCZ_BIT_STOP_IN_WAIT];
        timen_r <= w_data_r[`CCZ_BIT_TIMEN];
        wakeup_enable_r  <= w_data_r[`CCZ_BIT_WAKEUP_ENABLE];
      end
      if (~sleep_request_r | wake_evt) begin
        sleep_ack_r <= 1'b0;
      end else if (~sleep_ack_r & bus_idle & ~init_request_r) begin
        sleep_ack_r  <= 1'b1;
        // Setting captured at entry rules the whole sleep period
        wakeup_enable_sleep_r <= wakeup_enable_r;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      timer_r    <= `CCZ_TIMER_RESET;
      stamp_we_r <= 1'b0;
      stamp_r    <= `CCZ_TIMER_RESET;
      tx_pin_r   <= 1'b1;
      clk_stop_r <= 1'b0;
    end else begin
      if (~timen_r) begin
        timer_r <= `CCZ_TIMER_RESET;
      end else if (bit_clk_tick) begin
        timer_r <= timer_r + 16'h0001;
      end
      stamp_we_r <= timen_r & msg_acked;
      if (timen_r & msg_acked) begin
        stamp_r <= timer_r;
      end
      // Recessive is the only safe level once the engine may lose its clock
      tx_pin_r   <= (wait_stop | init_request_nxt) ? 1'b1 : tx_bit_in;
      clk_stop_r <= wait_stop;
    end
  end

  assign s_axi_awready   = awready_r;
  assign s_axi_wready    = wready_r;
  assign s_axi_bvalid    = bvalid_r;
  assign s_axi_bresp     = bresp_r;
  assign s_axi_arready   = arready_r;
  assign s_axi_rvalid    = rvalid_r;
  assign s_axi_rresp     = rresp_r;
  assign s_axi_rdata     = rdata_r;
  assign transmit_pin    = tx_pin_r;
  assign engine_init     = init_request_r;
  assign engine_sleep    = sleep_ack_r;
  assign bus_if_clk_stop = clk_stop_r;
  assign stamp_we        = stamp_we_r;
  assign stamp_value     = stamp_r;
  assign irq             = irq_r;

endmodule

// >>> ccz_can_ctl0_asserts.sv
// Checker of the control register zero block ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
module ccz_ctl0_chk (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire        tx_buffers_empty,
  input wire        rx_active_in,
  input wire        msg_acked,
  input wire        cpu_wait_mode,
  input wire        transmit_pin,
  input wire        engine_init,
  input wire        engine_sleep,
  input wire        bus_if_clk_stop,
  input wire        stamp_we
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  tx_wait_a: assert property (bus_if_clk_stop && cpu_wait_mode |-> transmit_pin)
    else $error("transmit pin dominant in wait");
  tx_init_a: assert property (engine_init |-> transmit_pin)
    else $error("transmit pin dominant in init");
  clk_stop_a: assert property (bus_if_clk_stop |-> $past(cpu_wait_mode))
    else $error("clock stop without wait");
  stamp_src_a: assert property (stamp_we |-> $past(msg_acked))
    else $error("stamp without acknowledge");
  sleep_idle_a: assert property ($rose(engine_sleep) |->
    $past(tx_buffers_empty) && !$past(rx_active_in))
    else $error("sleep entered on busy bus");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken with response pending");
endmodule
bind ccz_can_ctl0 ccz_ctl0_chk chk (.*);

// >>> ccz_can_node.sv
// Partner model: transceiver plus other nodes on a wired-AND CAN bus.
// Assumes the bench raises other_dom while another node sends a dominant bit.
`timescale 1ns/10ps
module ccz_can_node (
  input  wire transmit_pin,
  input  wire other_dom,
  output wire rx_pin
);
  // Dominant wins; an idle bus floats recessive, high
  assign rx_pin = transmit_pin & ~other_dom;
endmodule

// >>> ccz_defines.vh
// Register map, field positions and reset values of the control register zero block.
// Assumes inclusion by bare name from the block's design files.
`ifndef CCZ_DEFINES_VH
`define CCZ_DEFINES_VH

`define CCZ_ADDR_W        8
`define CCZ_OFF_CTL0      8'h00
`define CCZ_OFF_CTL1      8'h04
`define CCZ_OFF_TIMER     8'h08
`define CCZ_OFF_IRQ_STAT  8'h0C
`define CCZ_OFF_IRQ_MASK  8'h10

`define CCZ_BIT_RECEIVED_FRAME_FLAG     7
`define CCZ_BIT_RECEIVER_ACTIVE     6
`define CCZ_BIT_STOP_IN_WAIT     5
`define CCZ_BIT_BUS_SYNCHRONIZED     4
`define CCZ_BIT_TIMEN     3
`define CCZ_BIT_WAKEUP_ENABLE      2
`define CCZ_BIT_SLEEP_REQUEST     1
`define CCZ_BIT_INIT_REQUEST    0

`define CCZ_BIT_INIT_ACKNOWLEDGE    0
`define CCZ_BIT_SLEEP_ACKNOWLEDGE     1

`define CCZ_IRQ_RECEIVED_FRAME_FLAG     0
`define CCZ_IRQ_WAKE      1
`define CCZ_IRQ_W         2

`define CCZ_CTL0_RESET    8'h01
`define CCZ_TIMER_RESET   16'h0000
`define CCZ_MASK_RESET    2'h0

`define CCZ_RESP_OKAY     2'h0
`define CCZ_RESP_SLVERR   2'h2

`endif

// >>> ccz_sync.v
// Two-flop synchroniser, one stage pair per bit.
// Assumes the inputs are asynchronous to aclk; only the second stage may be read.
`timescale 1ns/10ps
module ccz_sync #(
  parameter W = 1
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [W-1:0] async_in,
  input  wire [W-1:0] reset_val,
  output wire [W-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_r;
      reg sync_r;
      always @(posedge aclk) begin
        if (!aresetn) begin
          meta_r <= reset_val[i];
          sync_r <= reset_val[i];
        end else begin
          meta_r <= async_in[i];
          sync_r <= meta_r;
        end
      end
      assign sync_out[i] = sync_r;
    end
  endgenerate
endmodule

// >>> tb_top.sv
// Self-checking bench of the control register zero block.
// Assumes the block answers each AXI4-Lite request within a few cycles; loopback is never used.
`timescale 1ns/10ps
module tb_top;
  reg aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  reg [7:0] awaddr = 0, araddr = 0;
  reg [31:0] wdata = 0, rd;
  reg [1:0] resp;
  reg [3:0] wstrb = 4'hF;
  reg fv = 0, ract = 0, syn = 0, txe = 0, tick = 0, ack = 0, wt = 0, txb = 1, dom = 0;
  wire awr, wr, bv, arr, rv, irq, txp, e_init, e_sleep, cstop, swe, rx;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] sval;
  integer num_errors = 0, check_count = 0, i;
  always #20 aclk = ~aclk;
  ccz_can_node node (.transmit_pin(txp), .other_dom(dom), .rx_pin(rx));
  ccz_can_ctl0 uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rready), .rx_pin(rx), .tx_bit_in(txb), .rx_frame_valid(fv),
    .rx_active_in(ract), .bus_synced_in(syn), .tx_buffers_empty(txe),
    .bit_clk_tick(tick), .msg_acked(ack), .cpu_wait_mode(wt), .transmit_pin(txp),
    .engine_init(e_init), .engine_sleep(e_sleep), .bus_if_clk_stop(cstop),
    .stamp_we(swe), .stamp_value(sval), .irq(irq));
  task summarize;
    if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input [8*12:1] name, input [31:0] seen, input [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("wrong value %0s exp %h seen %h", name, exp, seen);
    end
  endtask
  task tmo;
    num_errors = num_errors + 1;
    summarize;
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  task wr_reg(input [7:0] a, input [7:0] d);
    @(posedge aclk);
    awaddr <= a; wdata <= {24'h000000, d}; awv <= 1; wv <= 1; bready <= 1;
    for (i = 0; i < 50 && !(bv && bready); i = i + 1) begin
      @(posedge aclk);
      if (awr) awv <= 0;
      if (wr) wv <= 0;
      resp = bresp;
    end
    if (i == 50) tmo;
    bready <= 0;
    chk("bresp", resp, 2'h0);
  endtask
  task rd_reg(input [7:0] a, input [31:0] exp, input [1:0] er);
    @(posedge aclk);
    araddr <= a; arv <= 1; rready <= 1;
    for (i = 0; i < 50 && !(rv && rready); i = i + 1) begin
      @(posedge aclk);
      if (arr) arv <= 0;
      rd = rdata; resp = rresp;
    end
    if (i == 50) tmo;
    rready <= 0;
    chk("rdata", rd, exp);
    chk("rresp", resp, er);
  endtask
  task t_init;
    chk("engine_init", e_init, 1);
    rd_reg(8'h00, 32'h01, 2'h0);
    rd_reg(8'h04, 32'h01, 2'h0);
    wr_reg(8'h00, 8'h29);
    rd_reg(8'h00, 32'h01, 2'h0);
    wr_reg(8'h00, 8'h00);
    rd_reg(8'h04, 32'h00, 2'h0);
    #1;
    chk("engine_init", e_init, 0);
    syn <= 1; ract <= 1;
    rd_reg(8'h00, 32'h50, 2'h0);
    syn <= 0; ract <= 0;
    rd_reg(8'h40, 32'h00, 2'h2);
  endtask
  task t_frame;
    wr_reg(8'h10, 8'h01);
    @(posedge aclk) fv <= 1;
    @(posedge aclk) fv <= 0;
    cyc(3);
    chk("irq", irq, 1);
    rd_reg(8'h0C, 32'h01, 2'h0);
    cyc(3);
    chk("irq", irq, 0);
    wr_reg(8'h00, 8'h00);
    rd_reg(8'h00, 32'h80, 2'h0);
    wr_reg(8'h00, 8'h80);
    rd_reg(8'h00, 32'h00, 2'h0);
  endtask
  task t_timer;
    wr_reg(8'h00, 8'h08);
    repeat (5) begin
      @(posedge aclk) tick <= 1;
      @(posedge aclk) tick <= 0;
    end
    rd_reg(8'h08, 32'h05, 2'h0);
    @(posedge aclk) ack <= 1;
    @(posedge aclk) ack <= 0;
    #1;
    chk("stamp_we", swe, 1);
    chk("stamp", sval, 16'h0005);
    wr_reg(8'h00, 8'h00);
    rd_reg(8'h08, 32'h00, 2'h0);
  endtask
  task t_wait;
    txb <= 0;
    cyc(3);
    chk("txpin", txp, 0);
    wt <= 1;
    cyc(3);
    chk("clk_stop", cstop, 0);
    chk("txpin", txp, 0);
    wr_reg(8'h00, 8'h20);
    wt <= 1;
    cyc(3);
    chk("txpin", txp, 1);
    chk("clk_stop", cstop, 1);
    wt <= 0; txb <= 1;
    wr_reg(8'h00, 8'h00);
    cyc(3);
    chk("clk_stop", cstop, 0);
  endtask
  task t_sleep;
    wr_reg(8'h00, 8'h06); // wakeup enable set with the request
    cyc(4);
    chk("engine_sleep", e_sleep, 0);
    txe <= 1;
    for (i = 0; i < 50 && e_sleep !== 1'b1; i = i + 1) cyc(1);
    if (i == 50) tmo;
    rd_reg(8'h04, 32'h02, 2'h0);
    @(posedge aclk) dom <= 1;
    cyc(4);
    dom <= 0;
    for (i = 0; i < 50 && e_sleep !== 1'b0; i = i + 1) cyc(1);
    if (i == 50) tmo;
    chk("irq", irq, 0);
    rd_reg(8'h0C, 32'h02, 2'h0);
    rd_reg(8'h00, 32'h04, 2'h0);
    wstrb <= 4'h0;
    wr_reg(8'h10, 8'h03);
    wstrb <= 4'hF;
    rd_reg(8'h10, 32'h01, 2'h0);
  endtask
  initial begin
    // Reset spans four edges, more than the synchroniser needs
    cyc(4);
    aresetn <= 1;
    cyc(2);
    t_init;
    t_frame;
    t_timer;
    t_wait;
    t_sleep;
    summarize;
  end
endmodule
